// [ctx_flush_partner.sv]
`default_nettype none
// ***************************************************************
// cache flush and context source at the far side of each thread
// ***************************************************************
module ctx_flush_partner (
   input  wire logic                          sys_clk_in,     // clock
   input  wire logic                          sys_rst_in,     // sync reset
   input  wire logic [1:0]                    slow_in,        // slow flush
   input  wire logic [1:0]                    flush_req_in,   // flush wanted
   output logic      [1:0]                    flush_done_out, // flush done
   output logic      [1:0][pwr_pkg::CTX_W-1:0] ctx_data_out  // save words
);
   import pwr_pkg::*;
   for (genvar t = 0; t < 2; t++) begin : g_thr
      logic [2:0] wait_q;  // cycles spent flushing
      logic       done_q;  // flush finished level
      logic [3:0] idx_q;   // word index, runs freely
      logic       save_q;  // words are being taken
      logic [31:0] word;   // word for this index
      // count flush time, the slow side holds off three cycles
      always_ff @(posedge sys_clk_in) begin
         if (sys_rst_in || !flush_req_in[t]) begin
            wait_q <= 3'h0;
         end else if (wait_q != 3'h7) begin
            wait_q <= wait_q + 3'h1;
         end
      end
      // raise done once flushing has lasted long enough
      always_ff @(posedge sys_clk_in) begin
         done_q <= !sys_rst_in && flush_req_in[t] &&
                   (!slow_in[t] || wait_q >= 3'h3);
      end
      // restart the index where the save begins
      always_ff @(posedge sys_clk_in) begin
         if (sys_rst_in || (flush_req_in[t] && done_q)) begin
            idx_q <= 4'h0;
         end else begin
            idx_q <= idx_q + 4'h1;
         end
      end
      // mark the sixteen save cycles
      always_ff @(posedge sys_clk_in) begin
         if (sys_rst_in) begin
            save_q <= 1'h0;
         end else if (flush_req_in[t] && done_q) begin
            save_q <= 1'h1;
         end else if (idx_q == 4'hF) begin
            save_q <= 1'h0;
         end
      end
      assign word = 32'h5A00_0000 + 32'(t << 8) + 32'(idx_q);
      assign flush_done_out[t] = done_q;
      // outside a save the data changes every cycle
      assign ctx_data_out[t] = save_q ? word : ~word;
   end
endmodule
`default_nettype wire

// [ctx_store.sv]
`default_nettype none
// ***************************************************************
// per-thread context memory on the retained plane
// ***************************************************************
module ctx_store (
   input  wire logic                      sys_clk_in,  // clock
   input  wire logic                      wr_en_in,    // write strobe
   input  wire logic [pwr_pkg::CTX_AW-1:0] wr_addr_in, // write address
   input  wire logic [pwr_pkg::CTX_W-1:0]  wr_data_in, // write data
   input  wire logic [pwr_pkg::CTX_AW-1:0] rd_addr_in, // read address
   output logic      [pwr_pkg::CTX_W-1:0]  rd_data_out // registered read
);
   import pwr_pkg::*;
   // storage array, no reset: contents survive core power removal
   logic [CTX_W-1:0] mem_q [CTX_DEPTH];
   // write port
   always_ff @(posedge sys_clk_in) begin
      if (wr_en_in) begin
         mem_q[wr_addr_in] <= wr_data_in;
      end
   end
   // read port, data out of a register
   always_ff @(posedge sys_clk_in) begin
      rd_data_out <= mem_q[rd_addr_in];
   end
endmodule
`default_nettype wire

// [power_state_coordinator.sv]
`default_nettype none
module power_state_coordinator (
   input  wire logic                 sys_clk_in,      // clock
   input  wire logic                 sys_rst_in,      // sync reset, high
   input  wire pwr_pkg::core_state_e thr_req_in [2],  // thread requests
   input  wire logic                 ext_req_in,      // extended C-states
   input  wire pwr_pkg::sleep_state_e sleep_in,       // system sleep state
   input  wire pwr_pkg::link_state_e link_req_in,     // link state wanted
   input  wire logic                 disp_off_req_in, // display off wanted
   input  wire logic                 mem_idle_in,     // no memory traffic
   input  wire logic                 bank_open_in,    // any bank open
   input  wire logic                 mem_sr_req_in,   // self refresh wanted
   input  wire logic [1:0]           flush_done_in,   // per-thread flush done
   input  wire logic [1:0][pwr_pkg::CTX_W-1:0] ctx_data_in, // save data
   output logic      [1:0]           flush_req_out,   // per-thread flush
   output logic      [1:0]           ctx_rd_valid_out,// restore data valid
   output logic      [1:0][pwr_pkg::CTX_W-1:0] ctx_rd_data_out, // restore
   output logic                      mem_cke_out,     // memory clock enable
   output logic                      mem_sr_out,      // self refresh command
   output logic                      core_clk_stop_out, // core clock gated
   output logic                      proc_clk_stop_out, // processor clock off
   output logic                      low_volt_out,    // reduced voltage
   output logic                      core_volt_off_out, // core rail off
   output logic                      lfm_out,         // low freq/volt point
   output logic                      l2_shrink_out,   // cache shrink pulse
   output logic                      uncore_off_out,  // uncore power removed
   output pwr_pkg::status_s          status_out       // current states
);
   import pwr_pkg::*;

   // ***************************************************************
   // helper functions
   // ***************************************************************
   // shallower of two core states
   function automatic core_state_e shallow(input core_state_e a,
                                           input core_state_e b);
      shallow = (a < b) ? a : b;
   endfunction
   // system asleep (S3, S4 or S5)
   function automatic logic asleep(input sleep_state_e s);
      asleep = (s != S0);
   endfunction

   // ***************************************************************
   // per-thread deep power down sequence
   // ***************************************************************
   thread_state_e     th_q   [2];        // thread sequencer state
   logic [CTX_AW-1:0] cnt_q  [2];        // context word counter
   logic [1:0]        done_now;          // save finishing this cycle
   core_state_e       eff    [2];        // effective thread state

   genvar t;
   generate
      for (t = 0; t < THREADS; t++) begin : g_thr
         ctx_store u_ctx (
            .sys_clk_in  (sys_clk_in),
            .wr_en_in    (th_q[t] == TH_SAVE),
            .wr_addr_in  (cnt_q[t]),
            .wr_data_in  (ctx_data_in[t]),
            .rd_addr_in  (cnt_q[t]),
            .rd_data_out (ctx_rd_data_out[t])
         );
         assign done_now[t] = (th_q[t] == TH_SAVE) && (cnt_q[t] == CTX_LAST);
         always_ff @(posedge sys_clk_in) begin
            if (sys_rst_in) begin
               th_q[t]  <= TH_RUN;
               cnt_q[t] <= '0;
            end else begin
               case (th_q[t])
                  TH_RUN: begin
                     cnt_q[t] <= '0;
                     if (thr_req_in[t] == C6) begin
                        th_q[t] <= TH_FLUSH;
                     end
                  end
                  TH_FLUSH: begin
                     // wait for the cache flush to complete
                     if (flush_done_in[t]) begin
                        th_q[t] <= TH_SAVE;
                     end
                  end
                  TH_SAVE: begin
                     // one context word per cycle
                     cnt_q[t] <= cnt_q[t] + 4'h1;
                     if (done_now[t]) begin
                        th_q[t] <= TH_DOWN;
                     end
                  end
                  TH_DOWN: begin
                     cnt_q[t] <= '0;
                     if (thr_req_in[t] != C6) begin
                        th_q[t] <= TH_RESTORE;
                     end
                  end
                  TH_RESTORE: begin
                     // read back every word, then resume
                     cnt_q[t] <= cnt_q[t] + 4'h1;
                     if (cnt_q[t] == CTX_LAST) begin
                        th_q[t] <= TH_RUN;
                     end
                  end
                  default: th_q[t] <= TH_RUN;
               endcase
            end
         end
         // restore data valid one cycle after its read address
         always_ff @(posedge sys_clk_in) begin
            ctx_rd_valid_out[t] <= !sys_rst_in && (th_q[t] == TH_RESTORE);
         end
         // flush request to the core while flushing
         assign flush_req_out[t] = (th_q[t] == TH_FLUSH);
         // a thread counts as deep down only once saved
         always_comb begin
            if (th_q[t] == TH_DOWN) begin
               eff[t] = C6;
            end else if (th_q[t] == TH_RESTORE) begin
               eff[t] = C0;
            end else if (thr_req_in[t] == C6) begin
               eff[t] = C4;   // still flushing or saving
            end else begin
               eff[t] = thr_req_in[t];
            end
         end
      end
   endgenerate

   // ***************************************************************
   // level-two cache shrink by the last thread down
   // ***************************************************************
   logic all_down_next;   // both threads down after this cycle
   assign all_down_next = ((th_q[0] == TH_DOWN) || done_now[0]) &&
                          ((th_q[1] == TH_DOWN) || done_now[1]);
   always_ff @(posedge sys_clk_in) begin
      l2_shrink_out <= !sys_rst_in && all_down_next && (|done_now);
   end

   // ***************************************************************
   // core state and clock / voltage controls
   // ***************************************************************
   core_state_e core_d;   // resolved core state
   core_state_e core_q;   // registered core state
   assign core_d = shallow(eff[0], eff[1]);
   // registered core state for status
   always_ff @(posedge sys_clk_in) begin
      core_q <= sys_rst_in ? C0 : core_d;
   end
   // decode clock and voltage controls from the next core state
   always_ff @(posedge sys_clk_in) begin
      core_clk_stop_out <= !sys_rst_in && (core_d >= C2);
      proc_clk_stop_out <= !sys_rst_in && (core_d >= C3);
      low_volt_out      <= !sys_rst_in && (core_d inside {C3, C4});
      core_volt_off_out <= !sys_rst_in && (core_d == C6);
      lfm_out           <= !sys_rst_in && ext_req_in &&
                           (core_d inside {C1, C2, C4});
   end

   // ***************************************************************
   // memory clock-enable states
   // ***************************************************************
   mem_state_e mem_d;   // next memory state
   mem_state_e mem_q;   // memory state
   always_comb begin
      if (mem_sr_req_in || asleep(sleep_in)) begin
         mem_d = MEM_SR;      // contents kept by the device itself
      end else if (!mem_idle_in) begin
         mem_d = MEM_PWRUP;   // traffic pending
      end else if (!bank_open_in) begin
         mem_d = MEM_PPD;
      end else begin
         mem_d = MEM_APD;
      end
   end
   // registered memory state and pin levels, enable high in reset
   always_ff @(posedge sys_clk_in) begin
      mem_q       <= sys_rst_in ? MEM_PWRUP : mem_d;
      mem_cke_out <= sys_rst_in || (mem_d == MEM_PWRUP);
      mem_sr_out  <= !sys_rst_in && (mem_d == MEM_SR);
   end

   // ***************************************************************
   // chipset link, display and uncore states
   // ***************************************************************
   link_state_e link_d;   // permitted link state
   link_state_e link_q;   // link state
   disp_state_e disp_q;   // display state
   always_comb begin
      if (asleep(sleep_in)) begin
         link_d = LINK_L3;
      end else if (link_req_in == LINK_L1) begin
         link_d = (core_d >= C2 && core_d <= C4) ? LINK_L1 : LINK_L0S;
      end else if (link_req_in == LINK_L3) begin
         link_d = LINK_L0S;   // L3 refused while running
      end else begin
         link_d = link_req_in;
      end
   end
   // registered link, display and uncore states
   always_ff @(posedge sys_clk_in) begin
      link_q         <= sys_rst_in ? LINK_L0 : link_d;
      disp_q         <= sys_rst_in ? D0 :
                        (disp_off_req_in || asleep(sleep_in)) ? D3 : D0;
      uncore_off_out <= !sys_rst_in && asleep(sleep_in);
   end

   assign status_out = '{core: core_q, link: link_q, mem: mem_q,
                         disp: disp_q, sleep: sleep_in};

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (sys_rst_in);
   chk_cke_powerup: assert property (mem_cke_out == (mem_q == MEM_PWRUP))
      else $error("clock enable does not match powerup state");
   chk_ppd_banks: assert property ((mem_q == MEM_PPD) |->
      $past(!bank_open_in) && !mem_sr_out)
      else $error("precharge powerdown with an open bank");
   chk_apd_banks: assert property ((mem_q == MEM_APD) |->
      $past(bank_open_in) && !mem_cke_out && !mem_sr_out)
      else $error("active powerdown without an open bank");
   chk_sr_cke: assert property ((mem_q == MEM_SR) |->
      !mem_cke_out && mem_sr_out)
      else $error("self refresh with clock enable high");
   chk_link_l1: assert property ((link_q == LINK_L1) |->
      core_q inside {C2, C3, C4})
      else $error("link L1 outside C2 to C4");
   chk_link_l3: assert property ((link_q == LINK_L3) |->
      $past(sleep_in) != S0)
      else $error("link L3 while system awake");
   chk_link_awake: assert property ((sleep_in == S0 &&
      link_req_in == LINK_L0S) |=> (link_q == LINK_L0S))
      else $error("link L0s request not honoured");
   chk_c2_clock: assert property ((core_q == C2) |->
      core_clk_stop_out && !proc_clk_stop_out)
      else $error("C2 clock controls wrong");
   chk_c34_volt: assert property ((core_q inside {C3, C4}) |->
      proc_clk_stop_out && low_volt_out)
      else $error("deeper sleep without clock stop and low voltage");
   chk_c6_saved: assert property ($rose(core_volt_off_out) |->
      $past(th_q[0] == TH_SAVE || th_q[0] == TH_DOWN) &&
      $past(th_q[1] == TH_SAVE || th_q[1] == TH_DOWN))
      else $error("core voltage removed before context saved");
   // helper: consecutive save cycles of thread 0
   logic [4:0] save_run_q;   // save cycles counted so far
   always_ff @(posedge sys_clk_in) begin
      save_run_q <= (!sys_rst_in && th_q[0] == TH_SAVE) ?
                    save_run_q + 5'h01 : 5'h00;
   end
   chk_save_len: assert property ((th_q[0] == TH_FLUSH &&
      flush_done_in[0]) |=> (th_q[0] == TH_SAVE) ##16
      (th_q[0] == TH_DOWN && save_run_q == 5'h10))
      else $error("thread 0 save length wrong");
   chk_shrink_last: assert property (l2_shrink_out |->
      th_q[0] == TH_DOWN && th_q[1] == TH_DOWN)
      else $error("cache shrink before last thread down");
   chk_ext_lfm: assert property (lfm_out |->
      core_q inside {C1, C2, C4} && $past(ext_req_in))
      else $error("low operating point outside extended state");
   chk_disp_sleep: assert property ((sleep_in inside {S3, S4}) |=>
      disp_q == D3 && uncore_off_out)
      else $error("display on during S3 or S4");
   cov_c6: cover property (core_volt_off_out);
   cov_l1: cover property (link_q == LINK_L1);
   cov_sr: cover property (mem_q == MEM_SR ##1 mem_q == MEM_PWRUP);
   cov_restore: cover property ($fell(ctx_rd_valid_out[1]));
endmodule
`default_nettype wire

// [pwr_pkg.sv]
`default_nettype none
// ***************************************************************
// shared types and constants for the power state coordinator
// ***************************************************************
package pwr_pkg;
   // core idle states, binary codes ordered by depth
   typedef enum logic [2:0] {
      C0 = 3'h0,   // executing
      C1 = 3'h1,   // halt
      C2 = 3'h2,   // stop clock
      C3 = 3'h3,   // deeper sleep
      C4 = 3'h4,   // deeper sleep
      C6 = 3'h6    // deep power down
   } core_state_e;
   // chipset link power states
   typedef enum logic [1:0] {
      LINK_L0  = 2'h0,  // full on
      LINK_L0S = 2'h1,  // low exit latency
      LINK_L1  = 2'h2,  // longer exit latency
      LINK_L3  = 2'h3   // powered off
   } link_state_e;
   // memory clock-enable states
   typedef enum logic [1:0] {
      MEM_PWRUP = 2'h0,  // clock enable high
      MEM_PPD   = 2'h1,  // precharge powerdown
      MEM_APD   = 2'h2,  // active powerdown
      MEM_SR    = 2'h3   // self refresh
   } mem_state_e;
   // system sleep states
   typedef enum logic [1:0] {
      S0 = 2'h0,
      S3 = 2'h1,
      S4 = 2'h2,
      S5 = 2'h3
   } sleep_state_e;
   // display device states
   typedef enum logic {
      D0 = 1'h0,
      D3 = 1'h1
   } disp_state_e;
   // per-thread deep power down sequence
   typedef enum logic [2:0] {
      TH_RUN     = 3'h0,  // normal
      TH_FLUSH   = 3'h1,  // cache flush in progress
      TH_SAVE    = 3'h2,  // context copy to on-die memory
      TH_DOWN    = 3'h3,  // thread in deep power down
      TH_RESTORE = 3'h4   // context read back
   } thread_state_e;
   // status bundle seen by external logic
   typedef struct packed {
      core_state_e  core;
      link_state_e  link;
      mem_state_e   mem;
      disp_state_e  disp;
      sleep_state_e sleep;
   } status_s;
   localparam int THREADS   = 2;   // hardware threads
   localparam int CTX_W     = 32;  // context word width
   localparam int CTX_DEPTH = 16;  // context words per thread
   localparam int CTX_AW    = 4;   // context address width
   localparam logic [CTX_AW-1:0] CTX_LAST = 4'hF;  // last word index
endpackage
`default_nettype wire

// [test_power_state_coordinator.sv]
`default_nettype none
module test_power_state_coordinator;
   timeunit 1ns;
   timeprecision 100ps;
   import pwr_pkg::*;
   // ***************************************************************
   // stimulus rows: requests beside expected flags and states
   // ***************************************************************
   typedef struct packed {
      core_state_e  t0;     // thread 0 request
      core_state_e  t1;     // thread 1 request
      logic         ext;    // extended states wanted
      sleep_state_e slp;    // system sleep
      link_state_e  lreq;   // link state wanted
      logic [3:0]   ins;    // disp_off, idle, bank_open, sr_req
      logic [6:0]   flags;  // cke sr cstop pstop lowv lfm uoff
      core_state_e  core;   // expected core
      link_state_e  link;   // expected link
      mem_state_e   mem;    // expected memory
      disp_state_e  disp;   // expected display
   } row_s;
   logic                  sys_clk, sys_rst;          // clock, reset
   core_state_e           thr_req [2];               // thread requests
   logic                  ext_req, disp_off;         // level requests
   logic                  mem_idle, bank_open, sr_req; // memory side
   sleep_state_e          sleep;                     // system sleep
   link_state_e           link_req;                  // link request
   logic [1:0]            flush_done, flush_req;     // flush handshake
   logic [1:0]            rd_valid, slow;            // restore, pace
   logic [1:0][CTX_W-1:0] ctx_data, rd_data;         // context words
   logic                  cke, sr, cstop, pstop, lowv; // outputs
   logic                  voff, lfm, shrink, uoff;   // outputs
   status_s               status;                    // status bundle
   int                    err_count, checks, shrinks; // counters
   int                    vcnt [2];                  // restore words seen
   row_s                  rows [10];                 // table
   power_state_coordinator uut (
      .sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .thr_req_in(thr_req),
      .ext_req_in(ext_req), .sleep_in(sleep), .link_req_in(link_req),
      .disp_off_req_in(disp_off), .mem_idle_in(mem_idle),
      .bank_open_in(bank_open), .mem_sr_req_in(sr_req),
      .flush_done_in(flush_done), .ctx_data_in(ctx_data),
      .flush_req_out(flush_req), .ctx_rd_valid_out(rd_valid),
      .ctx_rd_data_out(rd_data), .mem_cke_out(cke), .mem_sr_out(sr),
      .core_clk_stop_out(cstop), .proc_clk_stop_out(pstop),
      .low_volt_out(lowv), .core_volt_off_out(voff), .lfm_out(lfm),
      .l2_shrink_out(shrink), .uncore_off_out(uoff), .status_out(status));
   ctx_flush_partner partner (
      .sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .slow_in(slow),
      .flush_req_in(flush_req), .flush_done_out(flush_done),
      .ctx_data_out(ctx_data));
   // clock, 5 ns period
   initial begin
      sys_clk = 1'h0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // ***************************************************************
   // helpers
   // ***************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask
   task automatic give_verdict();
      if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   function automatic logic [31:0] exp_word(input int t, input int k);
      return 32'h5A00_0000 + 32'(t << 8) + 32'(k);
   endfunction
   function automatic logic cond(input int s);
      case (s)
         0: return flush_req[0] === 1'h1;  // thread 0 flushing
         1: return flush_req[0] === 1'h0;  // thread 0 flush over
         default: return status.core === C6;
      endcase
   endfunction
   // bounded wait at falling edges; running out ends the run
   task automatic wait_until(input int s, input int n);
      int i = 0;
      while (!cond(s) && i < n) begin
         @(negedge sys_clk);
         i++;
      end
      if (!cond(s)) begin
         err_count++;
         give_verdict();
      end
   endtask
   // hold reset two cycles and look at the reset values
   task automatic do_reset();
      sys_rst = 1'h1;
      repeat (2) @(negedge sys_clk);
      check({cke, sr, cstop, pstop, lowv, voff, lfm, shrink, uoff, flush_req,
             rd_valid, status.core, status.link, status.mem, status.disp},
            {1'h1, 12'h000, C0, LINK_L0, MEM_PWRUP, D0});
      sys_rst = 1'h0;
   endtask
   // count shrink pulses and compare every restored word
   always @(negedge sys_clk) begin
      if (shrink === 1'h1) shrinks++;
      for (int t = 0; t < 2; t++) begin
         if (rd_valid[t] === 1'h1) begin
            check(rd_data[t], exp_word(t, vcnt[t]));
            vcnt[t]++;
         end
      end
   end
   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      sys_rst = 1'h1;
      thr_req = '{C0, C0};
      {ext_req, disp_off, mem_idle, bank_open, sr_req} = 5'h00;
      sleep = S0;
      link_req = LINK_L0;
      slow = 2'h0;
      {err_count, checks, shrinks} = 96'h0;
      vcnt = '{0, 0};
      rows = '{
         '{C0, C0, 1'h0, S0, LINK_L0, 4'h0, 7'h40, C0, LINK_L0, MEM_PWRUP, D0},
         '{C1, C1, 1'h1, S0, LINK_L1, 4'h4, 7'h02, C1, LINK_L0S, MEM_PPD, D0},
         '{C2, C4, 1'h0, S0, LINK_L1, 4'h6, 7'h10, C2, LINK_L1, MEM_APD, D0},
         '{C3, C3, 1'h1, S0, LINK_L0S, 4'h7, 7'h3C, C3, LINK_L0S, MEM_SR, D0},
         '{C4, C4, 1'h1, S0, LINK_L1, 4'hA, 7'h5E, C4, LINK_L1, MEM_PWRUP, D3},
         '{C2, C2, 1'h1, S0, LINK_L3, 4'h0, 7'h52, C2, LINK_L0S, MEM_PWRUP, D0},
         '{C0, C0, 1'h0, S3, LINK_L0, 4'h0, 7'h21, C0, LINK_L3, MEM_SR, D3},
         '{C0, C0, 1'h0, S4, LINK_L1, 4'h6, 7'h21, C0, LINK_L3, MEM_SR, D3},
         '{C0, C0, 1'h0, S5, LINK_L3, 4'h0, 7'h21, C0, LINK_L3, MEM_SR, D3},
         '{C0, C0, 1'h1, S0, LINK_L1, 4'h6, 7'h00, C0, LINK_L0S, MEM_APD, D0}};
      do_reset();
      // table rows: drive at a falling edge, answer one cycle later
      foreach (rows[r]) begin
         thr_req = '{rows[r].t0, rows[r].t1};
         ext_req = rows[r].ext;
         sleep = rows[r].slp;
         link_req = rows[r].lreq;
         {disp_off, mem_idle, bank_open, sr_req} = rows[r].ins;
         @(negedge sys_clk);
         check({cke, sr, cstop, pstop, lowv, lfm, uoff, voff, status},
               {rows[r].flags, 1'h0, rows[r].core, rows[r].link,
                rows[r].mem, rows[r].disp, rows[r].slp});
      end // rows also
      // thread 0 sleeps deep with a slow flush, thread 1 waits in C4
      {ext_req, disp_off, mem_idle, bank_open, sr_req} = 5'h00;
      sleep = S0;
      link_req = LINK_L0;
      slow = 2'h1;
      thr_req = '{C6, C4};
      wait_until(0, 5);
      check({lowv, status.core, flush_req}, {1'h1, C4, 2'h1});
      wait_until(1, 20);
      repeat (17) @(negedge sys_clk);
      check({voff, 4'(shrinks), status.core}, {1'h0, 4'h0, C4});
      // thread 1 follows with a prompt flush and is the last in
      slow = 2'h0;
      thr_req[1] = C6;
      wait_until(2, 40);
      repeat (3) @(negedge sys_clk);
      check({voff, cstop, pstop, lowv, 4'(shrinks)}, 8'hE1);
      // wake both threads, each restores sixteen words
      thr_req = '{C0, C0};
      repeat (24) @(negedge sys_clk);
      check({8'(vcnt[0]), 8'(vcnt[1]), voff, status.core},
            {8'h10, 8'h10, 1'h0, C0});
      // second reset in mid-run while asleep with busy requests
      sleep = S3;
      disp_off = 1'h1;
      thr_req = '{C3, C3};
      @(negedge sys_clk);
      do_reset();
      // inputs act from the first edge after release
      @(negedge sys_clk);
      check({cke, sr, cstop, pstop, lowv, lfm, uoff, voff, status},
            {7'h3D, 1'h0, C3, LINK_L3, MEM_SR, D3, S3});
      give_verdict();
   end
endmodule
`default_nettype wire
